// [logic/i2cms_cfg.svh]
// Offsets, field positions and timing for the two-wire master sequencer
`ifndef I2CMS_CFG_SVH
`define I2CMS_CFG_SVH
`define I2CMS_OFS_CTRL     12'h000
`define I2CMS_OFS_RXDATA   12'h004
`define I2CMS_CTRL_RESET   16'h0000
`define I2CMS_CTRL_MASK    16'h803f
`define I2CMS_BIT_ENABLE   15
`define I2CMS_BIT_ACKDATA  5
`define I2CMS_BIT_ACK      4
`define I2CMS_BIT_RECV     3
`define I2CMS_BIT_STOP     2
`define I2CMS_BIT_RSTART   1
`define I2CMS_BIT_START    0
`define I2CMS_CLK_NS       10
`define I2CMS_QUARTER_NS   2500
`define I2CMS_QUARTER_CYC  ((`I2CMS_QUARTER_NS + `I2CMS_CLK_NS - 1) / `I2CMS_CLK_NS)
`define I2CMS_START_LAST   5'h01
`define I2CMS_RSTART_LAST  5'h03
`define I2CMS_STOP_LAST    5'h02
`define I2CMS_RECV_LAST    5'h1f
`define I2CMS_ACK_LAST     5'h03
`define I2CMS_SAMPLE_QTR   2'h2
`define I2CMS_START_WATCH  1100
`endif

// [logic/i2cms_pkg.sv]
// Types shared by the two-wire master sequencer
package i2cms_pkg;
  typedef enum logic [2:0] {
    I2CMS_IDLE   = 3'h0,
    I2CMS_START  = 3'h1,
    I2CMS_RSTART = 3'h3,
    I2CMS_STOP   = 3'h2,
    I2CMS_RECV   = 3'h6,
    I2CMS_ACK    = 3'h7
  } i2cms_state_e;
  typedef logic [15:0] i2cms_ctrl_t;
endpackage

// [logic/i2cms_top.sv]
// Two-wire master sequence engine with APB control register
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "i2cms_cfg.svh"

// Functional notes
// R1: Ack trigger runs an acknowledge sequence on the lines, cleared when it ends.
// R2: Receive trigger clocks in one byte, cleared after the eighth bit.
// R3: Stop trigger generates a Stop condition, cleared when the Stop finishes.
// R4: Repeated-start trigger generates a Repeated Start, cleared at its end.
// R5: Start trigger generates a Start condition, cleared once it completes.
// R6: During acknowledge, data line is low for ack, released for not-ack.
module i2cms_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  import i2cms_pkg::*;

  localparam int unsigned QCYC = `I2CMS_QUARTER_CYC;
  localparam logic [8:0] QLAST = 9'(QCYC - 1);
  localparam int SEQ_MAX = `I2CMS_START_WATCH;
  localparam logic [10:0] SEQ_LIMIT = 11'(SEQ_MAX);

  i2cms_state_e state_q, state_d;
  i2cms_ctrl_t  ctrl_q, ctrl_d;
  logic [8:0]   tick_q, tick_d;
  logic [4:0]   step_q, step_d;
  logic [7:0]   rx_q, rx_d;
  logic         scl_oe_q, scl_oe_d;
  logic         sda_oe_q, sda_oe_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;
  logic [1:0]   sda_sync_q, sda_sync_d;
  logic [1:0]   scl_sync_q, scl_sync_d;
  logic         tick_end;
  logic         seq_end;
  logic         bus_write;
  logic [4:0]   last_step;
  logic [10:0]  start_age_q, start_age_d;

  assign tick_end  = (tick_q == QLAST);
  assign bus_write = psel && penable && pready_q && pwrite;

  always_comb begin
    case (state_q)
      I2CMS_START:  last_step = `I2CMS_START_LAST;
      I2CMS_RSTART: last_step = `I2CMS_RSTART_LAST;
      I2CMS_STOP:   last_step = `I2CMS_STOP_LAST;
      I2CMS_RECV:   last_step = `I2CMS_RECV_LAST;
      I2CMS_ACK:    last_step = `I2CMS_ACK_LAST;
      default:      last_step = 5'h00;
    endcase
  end

  assign seq_end = (state_q != I2CMS_IDLE) && tick_end && (step_q == last_step);

  // Pin inputs, two flops before anything reads them
  always_comb begin
    sda_sync_d = {sda_sync_q[0], sda_i};
    scl_sync_d = {scl_sync_q[0], scl_i};
  end

  // Register file and APB answer; no wait state, the outputs come from flops loaded in the setup cycle
  always_comb begin
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = psel && !penable;
    if (psel && !penable) begin
      case (paddr)
        `I2CMS_OFS_CTRL:   prdata_d = {16'h0000, ctrl_q};
        `I2CMS_OFS_RXDATA: prdata_d = {24'h000000, rx_q};
        default: begin
          prdata_d  = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
    // Triggers only load while idle, so a hardware clear never meets a write
    if (bus_write && (paddr == `I2CMS_OFS_CTRL)) begin
      if (state_q == I2CMS_IDLE) begin
        ctrl_d = pwdata[15:0] & `I2CMS_CTRL_MASK;
      end else begin
        ctrl_d[`I2CMS_BIT_ENABLE]  = pwdata[`I2CMS_BIT_ENABLE];
        ctrl_d[`I2CMS_BIT_ACKDATA] = pwdata[`I2CMS_BIT_ACKDATA];
      end
    end
    if (seq_end) begin
      case (state_q)
        I2CMS_START:  ctrl_d[`I2CMS_BIT_START]  = 1'b0; // [R5]
        I2CMS_RSTART: ctrl_d[`I2CMS_BIT_RSTART] = 1'b0; // [R4]
        I2CMS_STOP:   ctrl_d[`I2CMS_BIT_STOP]   = 1'b0; // [R3]
        I2CMS_RECV:   ctrl_d[`I2CMS_BIT_RECV]   = 1'b0; // [R2]
        I2CMS_ACK:    ctrl_d[`I2CMS_BIT_ACK]    = 1'b0; // [R1]
        default:      ctrl_d = ctrl_q;
      endcase
    end
    if (!ctrl_d[`I2CMS_BIT_ENABLE]) begin
      ctrl_d[`I2CMS_BIT_ACK:`I2CMS_BIT_START] = 5'h00;
    end
  end

  // Sequencer: each step lasts one quarter of a bit period
  always_comb begin
    state_d  = state_q;
    tick_d   = tick_end ? 9'h000 : tick_q + 9'h001;
    step_d   = tick_end ? step_q + 5'h01 : step_q;
    rx_d     = rx_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    case (state_q)
      I2CMS_IDLE: begin
        tick_d = 9'h000;
        step_d = 5'h00;
        // Lowest bit wins when software sets several at once
        if (!ctrl_q[`I2CMS_BIT_ENABLE]) begin
          scl_oe_d = 1'b0;
          sda_oe_d = 1'b0;
        end else if (ctrl_q[`I2CMS_BIT_START]) begin
          state_d = I2CMS_START;
        end else if (ctrl_q[`I2CMS_BIT_RSTART]) begin
          state_d = I2CMS_RSTART;
        end else if (ctrl_q[`I2CMS_BIT_STOP]) begin
          state_d = I2CMS_STOP;
        end else if (ctrl_q[`I2CMS_BIT_RECV]) begin
          state_d = I2CMS_RECV;
        end else if (ctrl_q[`I2CMS_BIT_ACK]) begin
          state_d = I2CMS_ACK;
        end
      end
      I2CMS_START: begin
        // Data falls while clock is high, then clock is pulled low
        sda_oe_d = 1'b1; // [R5]
        scl_oe_d = (step_q != 5'h00);
      end
      I2CMS_RSTART: begin
        // Release data with clock low, raise clock, then a Start
        sda_oe_d = (step_q >= 5'h02); // [R4]
        scl_oe_d = (step_q == 5'h00) || (step_q == 5'h03);
      end
      I2CMS_STOP: begin
        // Data low under a low clock, clock rises, then data rises
        sda_oe_d = (step_q != 5'h02); // [R3]
        scl_oe_d = (step_q == 5'h00);
      end
      I2CMS_RECV: begin
        sda_oe_d = 1'b0;
        scl_oe_d = (step_q[1:0] == 2'h0) || (step_q[1:0] == 2'h3); // [R2]
        if (tick_end && (step_q[1:0] == `I2CMS_SAMPLE_QTR)) begin
          rx_d = {rx_q[6:0], sda_sync_q[1]};
        end
      end
      I2CMS_ACK: begin
        sda_oe_d = !ctrl_q[`I2CMS_BIT_ACKDATA]; // [R6]
        scl_oe_d = (step_q == 5'h00) || (step_q == 5'h03); // [R1]
      end
      default: begin
        state_d = I2CMS_IDLE;
      end
    endcase
    if (seq_end || !ctrl_q[`I2CMS_BIT_ENABLE]) begin
      state_d = I2CMS_IDLE;
      // Keep holding the clock low after a byte or ack; a Stop leaves both free
      if (state_q == I2CMS_ACK) begin
        sda_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= I2CMS_IDLE;
      ctrl_q     <= `I2CMS_CTRL_RESET;
      tick_q     <= 9'h000;
      step_q     <= 5'h00;
      rx_q       <= 8'h00;
      scl_oe_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
      prdata_q   <= 32'h00000000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end else begin
      state_q    <= state_d;
      ctrl_q     <= ctrl_d;
      tick_q     <= tick_d;
      step_q     <= step_d;
      rx_q       <= rx_d;
      scl_oe_q   <= scl_oe_d;
      sda_oe_q   <= sda_oe_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      sda_sync_q <= sda_sync_d;
      scl_sync_q <= scl_sync_d;
    end
  end

  // Watchdog on the start trigger; a delay range this long would choke the property tools
  always_comb begin
    start_age_d = 11'h000;
    if (ctrl_q[`I2CMS_BIT_START] && (start_age_q != SEQ_LIMIT)) begin
      start_age_d = start_age_q + 11'h001;
    end else if (ctrl_q[`I2CMS_BIT_START]) begin
      start_age_d = start_age_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_age_q <= 11'h000;
    end else begin
      start_age_q <= start_age_d;
    end
  end

  // Open-drain pins: the driven level is always low
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = scl_oe_q;
  assign sda_oe  = sda_oe_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  a_start_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (state_q == I2CMS_START) && seq_end |=> !ctrl_q[`I2CMS_BIT_START] && (state_q == I2CMS_IDLE))
    else $error("start trigger not cleared at end of start");

  a_start_bound: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    start_age_q < SEQ_LIMIT)
    else $error("start sequence did not finish in time");

  // Enable drops one edge before the engine sees it, hence the escape term
  a_start_busy: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (state_q == I2CMS_START) |-> ctrl_q[`I2CMS_BIT_START] || !ctrl_q[`I2CMS_BIT_ENABLE])
    else $error("start trigger low while start runs");

  a_start_lines: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (state_q == I2CMS_START) && (step_q == 5'h01) && (tick_q != 9'h000) |-> sda_oe_q && scl_oe_q)
    else $error("start did not pull both lines low");

  a_rstart_lines: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (state_q == I2CMS_RSTART) && (step_q == 5'h01) && (tick_q != 9'h000) |-> !sda_oe_q && !scl_oe_q)
    else $error("repeated start did not free both lines");

  a_stop_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (state_q == I2CMS_STOP) && (step_q == 5'h01) && (tick_q != 9'h000) |-> sda_oe_q && !scl_oe_q)
    else $error("stop clock rose with data free");

  a_recv_lines: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (state_q == I2CMS_RECV) && (step_q[1:0] == 2'h1) && (tick_q != 9'h000) |-> !sda_oe_q && !scl_oe_q)
    else $error("receive did not free the lines for a bit");

  a_ack_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (state_q == I2CMS_ACK) && (step_q == 5'h01) && (tick_q != 9'h000) |-> !scl_oe_q)
    else $error("ack clock pulse missing");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q)
    else $error("bus ready held longer than one cycle");

  a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_q |-> pready_q)
    else $error("bus error without ready");

  a_rstart_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (state_q == I2CMS_RSTART) && seq_end |=> !ctrl_q[`I2CMS_BIT_RSTART] && !scl_oe_q == 1'b0)
    else $error("repeated start trigger not cleared");

  a_stop_lines: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (state_q == I2CMS_STOP) && seq_end |=> !ctrl_q[`I2CMS_BIT_STOP] && !sda_oe_q && !scl_oe_q)
    else $error("stop did not release both lines");

  a_recv_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (state_q == I2CMS_RECV) && seq_end |-> (step_q == 5'h1f) ##1 !ctrl_q[`I2CMS_BIT_RECV])
    else $error("receive trigger not cleared after eighth bit");

  a_recv_busy: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (state_q == I2CMS_RECV) && !seq_end |=> ctrl_q[`I2CMS_BIT_RECV] || !ctrl_q[`I2CMS_BIT_ENABLE])
    else $error("receive trigger dropped mid-byte");

  a_ack_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (state_q == I2CMS_ACK) && seq_end |=> !ctrl_q[`I2CMS_BIT_ACK] && scl_oe_q)
    else $error("ack trigger not cleared or clock not held");

  a_ack_level: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    (state_q == I2CMS_ACK) && (step_q != 5'h00) && $stable(ctrl_q) |-> sda_oe_q == !ctrl_q[`I2CMS_BIT_ACKDATA])
    else $error("ack data level wrong");
endmodule

// [dv/i2cms_slave_model.sv]
// Behavioural slave that returns one byte on the data line
`timescale 1ns/1ps
module i2cms_slave_model (
  input  wire logic       scl,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_en,
  output logic            sda_oe
);
  logic [3:0] bit_cnt;
  // Data moves only on a falling clock edge, so it is stable while the line is high
  always @(negedge scl or negedge tx_en) begin
    if (!tx_en) bit_cnt <= 4'h0;
    else bit_cnt <= bit_cnt + 4'h1;
  end
  // Released after the eighth bit so the master can drive its acknowledge
  assign sda_oe = tx_en && (bit_cnt < 4'h8) && !tx_byte[3'h7 - bit_cnt[2:0]];
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`include "i2cms_cfg.svh"
module tb_top;
  import i2cms_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        scl_oe, sda_oe, scl_o, sda_o, s_oe, tx_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  tx_byte;
  int          n_fail, num_checks;
  // Both lines have pull-ups, so a released line reads high
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || s_oe);

  i2cms_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  i2cms_slave_model i_slave (.scl(scl), .tx_byte(tx_byte), .tx_en(tx_en), .sda_oe(s_oe));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: line level %b, expected %b", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; read data and error are taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        n_fail++;
        $display("mismatch at %0t: no bus answer", $time);
        finish_test();
      end
      rd = prdata;
      err = pslverr;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Fires one trigger, checks both lines early in the sequence, polls until hardware clears it
  task automatic run_seq(input int b, input logic [31:0] keep, input logic ms, md, es, ed);
    int n;
    apb(1'b1, `I2CMS_OFS_CTRL, keep | (32'h1 << b));
    apb(1'b0, `I2CMS_OFS_CTRL, 32'h0);
    chk_pin(rd[b], 1'b1);
    repeat (100) @(posedge pclk);
    chk_pin(scl, ms);
    chk_pin(sda, md);
    n = 0;
    do begin
      apb(1'b0, `I2CMS_OFS_CTRL, 32'h0);
      n++;
      if (n > 6000) begin
        n_fail++;
        $display("mismatch at %0t: trigger never cleared", $time);
        finish_test();
      end
    end while (rd[b] !== 1'b0);
    chk_reg(rd, keep);
    chk_pin(scl, es);
    chk_pin(sda, ed);
    $display("test sequence %0d done", b);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, tx_en} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_byte = 8'hff;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'h1d4e));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `I2CMS_OFS_CTRL, 32'h0);
    chk_reg(rd, {16'h0, `I2CMS_CTRL_RESET});
    apb(1'b0, 12'h0f8, 32'h0);
    chk_pin(err, 1'b1);
    chk_reg(rd, 32'h0);
    $display("test registers done");
    run_seq(`I2CMS_BIT_START, 32'h8000, 1'b1, 1'b0, 1'b0, 1'b0);
    // First byte is all ones, the second random; the first is followed by ack, the second by not-ack
    for (int i = 0; i < 2; i++) begin
      tx_en <= 1'b1;
      run_seq(`I2CMS_BIT_RECV, 32'h8000, 1'b0, tx_byte[7], 1'b0, 1'b1);
      tx_en <= 1'b0;
      apb(1'b0, `I2CMS_OFS_RXDATA, 32'h0);
      chk_reg(rd, {24'h0, tx_byte});
      run_seq(`I2CMS_BIT_ACK, 32'h8000 | (i << 5), 1'b0, i[0], 1'b0, 1'b1);
      tx_byte <= 8'($urandom_range(255, 0));
    end
    run_seq(`I2CMS_BIT_RSTART, 32'h8020, 1'b0, 1'b1, 1'b0, 1'b0);
    run_seq(`I2CMS_BIT_STOP, 32'h8000, 1'b0, 1'b0, 1'b1, 1'b1);
    finish_test();
  end
endmodule
